// ==== hdl/pmbsa_slave.v ====
/*
 Serial management slave: addressing, bytes, stretch, check byte, alert.
 Assumes the device gives exp_len per command and answers rd_req on this clock.
*/
`timescale 1ns/1ps
`include "pmbsa_consts.vh"
module pmbsa_slave #(
   parameter [22:0] STRETCH_MAX_CYC = `PMBSA_STRETCH_MAX_CYC
) (
   input wire core_clk,
   input wire rst_n,
   input wire scl_in,
   output reg scl_out,
   output reg scl_oe,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   output reg alert_out,
   output reg alert_oe,
   input wire [7:0] address_high_digit_pin,
   input wire [7:0] address_low_digit_pin,
   input wire fault_active,
   input wire [1:0] exp_len,
   output reg [7:0] cmd_code,
   output reg cmd_valid,
   output reg [15:0] cmd_word,
   output wire [10:0] cmd_mantissa,
   output wire [4:0] cmd_exponent,
   output reg store_default,
   output reg bad_frame,
   output reg rd_req,
   input wire rd_valid,
   input wire [15:0] rd_data,
   output reg alert_response_mode_config,
   output reg [6:0] slave_addr
);
   // ****************************************************************
   // States
   // ****************************************************************
   localparam [5:0] S_IDLE = 6'h01;
   localparam [5:0] S_RXB = 6'h02;
   localparam [5:0] S_ACK = 6'h04;
   localparam [5:0] S_HOLD = 6'h08;
   localparam [5:0] S_TXB = 6'h10;
   localparam [5:0] S_RACK = 6'h20;

   wire [1:0] bus_s;
   wire scl_s, sda_s;
   wire [7:0] crc;
   reg scl_q, sda_q;
   reg [5:0] state;
   reg [7:0] shreg;
   reg [3:0] bitcnt;
   reg first_byte, in_frame, is_read, is_ara;
   reg [2:0] byte_idx;
   reg [7:0] dbuf [0:2];
   reg [7:0] tx_sh;
   reg [2:0] tx_idx;
   reg [15:0] rd_word;
   reg [1:0] rd_len;
   reg [22:0] hold_cnt;
   reg data_ok, mack, fault_q, alert_clr, addr_taken, pec_clr, pec_upd;
   reg [7:0] pec_byte;

   // ****************************************************************
   // Pin sampling and bus events
   // ****************************************************************
   // Oversampling at 200 MHz covers either bus rate
   pmbsa_sync #(.W(2)) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .async_in({scl_in, sda_in}),
      .sync_out(bus_s)
   );

   assign scl_s = bus_s[1];
   assign sda_s = bus_s[0];

   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
   wire bus_stop = scl_s & scl_q & ~sda_q & sda_s;

   pmbsa_pec u_pec (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .clear(pec_clr),
      .update(pec_upd),
      .data_in(pec_byte),
      .crc(crc)
   );

   // ****************************************************************
   // Address and data helpers
   // ****************************************************************
   function [2:0] digit_of;
      input [7:0] lvl;
      begin
         if (lvl < `PMBSA_DIG_T1) digit_of = 3'h0;
         else if (lvl < `PMBSA_DIG_T2) digit_of = 3'h1;
         else if (lvl < `PMBSA_DIG_T3) digit_of = 3'h2;
         else if (lvl < `PMBSA_DIG_T4) digit_of = 3'h3;
         else if (lvl < `PMBSA_DIG_T5) digit_of = 3'h4;
         else if (lvl < `PMBSA_DIG_T6) digit_of = 3'h5;
         else if (lvl < `PMBSA_DIG_T7) digit_of = 3'h6;
         else digit_of = 3'h7;
      end
   endfunction

   // One address at a time
   wire ara_active = alert_response_mode_config & alert_oe;
   wire addr_hit = ara_active ? (shreg == {`PMBSA_ARA_ADDR, 1'b1})
                              : (shreg[7:1] == slave_addr);
   wire vout_mode_cmd = (cmd_code == `PMBSA_CMD_VOUT_MODE);
   wire ara_cfg_cmd = (cmd_code == `PMBSA_CMD_ARA_CFG);
   wire [1:0] eff_len = (vout_mode_cmd | ara_cfg_cmd) ? 2'h1 : exp_len;
   wire [2:0] n_data = byte_idx - 3'h1;
   wire len_plain = (n_data == {1'b0, eff_len});
   wire len_pec = (n_data == ({1'b0, eff_len} + 3'h1));
   wire pec_good = len_pec & (crc == 8'h00);
   wire hold_done = is_ara | vout_mode_cmd | rd_valid | (hold_cnt == STRETCH_MAX_CYC);

   // Response bytes: data low byte first, then the check byte
   wire [7:0] tx_next = is_ara ? ((tx_idx == 3'h0) ? {slave_addr, 1'b0} :
                                  (tx_idx == 3'h1) ? crc : 8'hff) :
                        (tx_idx < {1'b0, rd_len}) ?
                           ((tx_idx == 3'h0) ? rd_word[7:0] : rd_word[15:8]) :
                        (tx_idx == {1'b0, rd_len}) ? crc : 8'hff;

   assign cmd_mantissa = cmd_word[10:0];
   assign cmd_exponent = cmd_word[15:11];

   // ****************************************************************
   // Address capture after reset
   // ****************************************************************
   // Read once; later pin noise cannot move the address
   always @(posedge core_clk) begin
      if (!rst_n) begin
         addr_taken <= 1'b0;
         slave_addr <= 7'h00;
      end else if (!addr_taken) begin
         addr_taken <= 1'b1;
         slave_addr <= {1'b0, digit_of(address_high_digit_pin),
                        digit_of(address_low_digit_pin)};
      end
   end

   // ****************************************************************
   // Alert latch
   // ****************************************************************
   // A new fault wins over a same-cycle clear
   always @(posedge core_clk) begin
      if (!rst_n) begin
         fault_q <= 1'b0;
         alert_oe <= 1'b0;
         alert_out <= 1'b0;
      end else begin
         fault_q <= fault_active;
         if (fault_active & ~fault_q) begin
            alert_oe <= 1'b1;
         end else if (alert_clr) begin
            alert_oe <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Byte engine
   // ****************************************************************
   always @(posedge core_clk) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         // Datapath registers are loaded before any use, so not reset
         state <= S_IDLE;
         in_frame <= 1'b0;
         is_read <= 1'b0;
         byte_idx <= 3'h0;
         alert_clr <= 1'b0;
         pec_clr <= 1'b0;
         pec_upd <= 1'b0;
         scl_out <= 1'b0;
         scl_oe <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
         cmd_code <= 8'h00;
         cmd_valid <= 1'b0;
         cmd_word <= 16'h0000;
         store_default <= 1'b0;
         bad_frame <= 1'b0;
         rd_req <= 1'b0;
         alert_response_mode_config <= 1'b0;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         cmd_valid <= 1'b0;
         store_default <= 1'b0;
         bad_frame <= 1'b0;
         rd_req <= 1'b0;
         alert_clr <= 1'b0;
         pec_clr <= 1'b0;
         pec_upd <= 1'b0;
         if (bus_start) begin
            state <= S_RXB;
            bitcnt <= 4'h0;
            first_byte <= 1'b1;
            is_read <= 1'b0;
            byte_idx <= 3'h0;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            in_frame <= 1'b1;
            // Repeated start keeps the check byte running
            if (!in_frame) begin
               pec_clr <= 1'b1;
            end
         end else if (bus_stop) begin
            state <= S_IDLE;
            in_frame <= 1'b0;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            if (!is_read && byte_idx != 3'h0) begin
               if (len_plain | pec_good) begin
                  if (vout_mode_cmd) begin
                     bad_frame <= 1'b1;
                  end else begin
                     cmd_valid <= 1'b1;
                     cmd_word <= (eff_len == 2'h2) ? {dbuf[1], dbuf[0]} :
                                 (eff_len == 2'h1) ? {8'h00, dbuf[0]} : 16'h0000;
                     if (ara_cfg_cmd) begin
                        alert_response_mode_config <= dbuf[0][`PMBSA_ARA_MODE_BIT];
                     end
                     if (cmd_code == `PMBSA_CMD_CLEAR_FAULTS) begin
                        alert_clr <= 1'b1;
                     end
                     // Only this command commits settings
                     if (cmd_code == `PMBSA_CMD_STORE_DEFAULT_ALL) begin
                        store_default <= 1'b1;
                     end
                  end
               end else begin
                  bad_frame <= 1'b1;
               end
            end
         end else begin
            case (state)
               S_RXB: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda_s};
                     bitcnt <= bitcnt + 4'h1;
                  end else if (scl_fall && bitcnt == 4'h8) begin
                     if (first_byte) begin
                        if (addr_hit) begin
                           first_byte <= 1'b0;
                           is_read <= shreg[0];
                           is_ara <= ara_active;
                           sda_oe <= 1'b1;
                           state <= S_ACK;
                           pec_upd <= 1'b1;
                           pec_byte <= shreg;
                        end else begin
                           state <= S_IDLE;
                        end
                     end else begin
                        if (byte_idx == 3'h0) begin
                           cmd_code <= shreg;
                        end else if (byte_idx <= 3'h3) begin
                           dbuf[byte_idx[1:0] - 2'h1] <= shreg;
                        end
                        if (byte_idx != 3'h7) begin
                           byte_idx <= byte_idx + 3'h1;
                        end
                        sda_oe <= 1'b1;
                        state <= S_ACK;
                        pec_upd <= 1'b1;
                        pec_byte <= shreg;
                     end
                  end
               end
               S_ACK: begin
                  if (scl_fall) begin
                     sda_oe <= 1'b0;
                     bitcnt <= 4'h0;
                     if (is_read) begin
                        // Stretch until response data is ready
                        state <= S_HOLD;
                        scl_oe <= 1'b1;
                        hold_cnt <= 23'h000000;
                        tx_idx <= 3'h0;
                        data_ok <= 1'b0;
                        if (vout_mode_cmd) begin
                           rd_word <= {8'h00, `PMBSA_VOUT_MODE_VAL};
                           rd_len <= 2'h1;
                        end else begin
                           rd_len <= exp_len;
                           rd_req <= ~is_ara;
                        end
                     end else begin
                        state <= S_RXB;
                     end
                  end
               end
               S_HOLD: begin
                  hold_cnt <= hold_cnt + 23'h000001;
                  if (!data_ok) begin
                     if (hold_done) begin
                        data_ok <= 1'b1;
                        if (rd_valid) begin
                           rd_word <= rd_data;
                        end else if (!is_ara && !vout_mode_cmd) begin
                           // Give up at the stretch limit; all-ones marks no data
                           rd_word <= 16'hffff;
                        end
                     end
                  end else begin
                     tx_sh <= tx_next;
                     sda_oe <= ~tx_next[7];
                     pec_upd <= 1'b1;
                     pec_byte <= tx_next;
                     tx_idx <= 3'h1;
                     state <= S_TXB;
                  end
               end
               S_TXB: begin
                  // Free the clock a cycle after data is set
                  scl_oe <= 1'b0;
                  if (scl_fall) begin
                     if (bitcnt == 4'h7) begin
                        sda_oe <= 1'b0;
                        state <= S_RACK;
                     end else begin
                        // No arbitration: bits go out blind
                        tx_sh <= {tx_sh[6:0], 1'b0};
                        sda_oe <= ~tx_sh[6];
                        bitcnt <= bitcnt + 4'h1;
                     end
                  end
               end
               S_RACK: begin
                  if (scl_rise) begin
                     mack <= ~sda_s;
                  end else if (scl_fall) begin
                     if (mack) begin
                        tx_sh <= tx_next;
                        sda_oe <= ~tx_next[7];
                        pec_upd <= 1'b1;
                        pec_byte <= tx_next;
                        if (tx_idx != 3'h7) begin
                           tx_idx <= tx_idx + 3'h1;
                        end
                        bitcnt <= 4'h0;
                        state <= S_TXB;
                     end else begin
                        state <= S_IDLE;
                        // Alert read done: back to own address
                        if (is_ara) begin
                           alert_clr <= 1'b1;
                        end
                     end
                  end
               end
               default: begin
                  state <= S_IDLE;
               end
            endcase
         end
      end
   end
endmodule

// ==== hdl/pmbsa_consts.vh ====
/*
 Constants of the serial slave with alert and pin-set address.
 Assumes 200 MHz core clock and an 8-bit per-pin resistor reading in kilohm units.
*/
`ifndef PMBSA_CONSTS_VH
`define PMBSA_CONSTS_VH

`define PMBSA_ARA_ADDR 7'h0c
`define PMBSA_CMD_CLEAR_FAULTS 8'h03
`define PMBSA_CMD_STORE_DEFAULT_ALL 8'h11
`define PMBSA_CMD_VOUT_MODE 8'h20
`define PMBSA_CMD_ARA_CFG 8'hd6
`define PMBSA_ARA_MODE_BIT 4
`define PMBSA_VOUT_MODE_VAL 8'h14
`define PMBSA_PEC_POLY 8'h07
`define PMBSA_STRETCH_MAX_CYC 23'h6acfc0

// Digit boundaries in kilohm
`define PMBSA_DIG_T1 8'h0c
`define PMBSA_DIG_T2 8'h13
`define PMBSA_DIG_T3 8'h1d
`define PMBSA_DIG_T4 8'h2d
`define PMBSA_DIG_T5 8'h44
`define PMBSA_DIG_T6 8'h69
`define PMBSA_DIG_T7 8'ha1

`endif

// ==== hdl/pmbsa_sync.v ====
/*
 Two-flop pin synchroniser.
 Assumes idle-high lines, so it resets high.
*/
`timescale 1ns/1ps
module pmbsa_sync #(
   parameter W = 2
) (
   input wire core_clk,
   input wire rst_n,
   input wire [W-1:0] async_in,
   output reg [W-1:0] sync_out
);
   reg [W-1:0] meta;

   always @(posedge core_clk) begin
      if (!rst_n) begin
         meta <= {W{1'b1}};
         sync_out <= {W{1'b1}};
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule

// ==== hdl/pmbsa_pec.v ====
/*
 CRC-8 check byte accumulator.
 Assumes one-cycle clear and update pulses.
*/
`timescale 1ns/1ps
`include "pmbsa_consts.vh"
module pmbsa_pec (
   input wire core_clk,
   input wire rst_n,
   input wire clear,
   input wire update,
   input wire [7:0] data_in,
   output reg [7:0] crc
);
   function [7:0] crc_byte;
      input [7:0] c;
      input [7:0] d;
      integer i;
      reg [7:0] r;
      begin
         r = c ^ d;
         for (i = 0; i < 8; i = i + 1) begin
            r = r[7] ? ((r << 1) ^ `PMBSA_PEC_POLY) : (r << 1);
         end
         crc_byte = r;
      end
   endfunction

   always @(posedge core_clk) begin
      if (!rst_n) begin
         crc <= 8'h00;
      end else if (clear) begin
         crc <= 8'h00;
      end else if (update) begin
         crc <= crc_byte(crc, data_in);
      end
   end
endmodule

// ==== test/pmbsa_slave_asserts.sv ====
/*
 Assertions on the slave's ports, bound into it.
 Assumes one clock domain; STRETCH_MAX_CYC follows the design.
*/
`timescale 1ns/1ps
`include "pmbsa_consts.vh"
module pmbsa_slave_asserts #(
   parameter [22:0] STRETCH_MAX_CYC = 23'h6acfc0
) (
   input wire core_clk,
   input wire rst_n,
   input wire scl_oe,
   input wire alert_oe,
   input wire fault_active,
   input wire rd_valid,
   input wire [7:0] cmd_code,
   input wire cmd_valid,
   input wire [15:0] cmd_word,
   input wire [10:0] cmd_mantissa,
   input wire [4:0] cmd_exponent,
   input wire store_default,
   input wire bad_frame,
   input wire alert_response_mode_config,
   input wire [6:0] slave_addr
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // ****************
   // Helper logic
   // ****************
   // Counter instead of a long repetition
   reg [23:0] low_run;
   always @(posedge core_clk) begin
      if (!rst_n || !scl_oe)
         low_run <= 24'h000000;
      else
         low_run <= low_run + 24'h000001;
   end
   sequence s_data_ready;
      scl_oe && rd_valid;
   endsequence
   sequence s_clock_freed;
      ##[1:3] !scl_oe;
   endsequence
   sequence s_clear_cmd;
      cmd_valid && cmd_code == `PMBSA_CMD_CLEAR_FAULTS && !fault_active;
   endsequence
   // ****************
   // Properties
   // ****************
   a_stretch_bound:
      assert property (low_run <= {1'h0, STRETCH_MAX_CYC} + 24'h000008)
      else $error("clock held low too long");
   a_stretch_release:
      assert property (s_data_ready |-> s_clock_freed)
      else $error("clock not freed after read data");
   a_alert_raise:
      assert property ($rose(fault_active) |-> ##[1:3] alert_oe)
      else $error("alert not raised");
   a_alert_clear:
      assert property (s_clear_cmd |-> ##[0:2] !alert_oe)
      else $error("clear faults left alert");
   a_alert_cause:
      assert property ($fell(alert_oe) |->
         cmd_code == `PMBSA_CMD_CLEAR_FAULTS || alert_response_mode_config)
      else $error("alert dropped without cause");
   a_mode_select:
      assert property (cmd_valid && cmd_code == `PMBSA_CMD_ARA_CFG |->
         ##[0:2] alert_response_mode_config == cmd_word[`PMBSA_ARA_MODE_BIT])
      else $error("mode bit not taken");
   a_store_only_cmd:
      assert property (store_default |->
         cmd_code == `PMBSA_CMD_STORE_DEFAULT_ALL && !bad_frame)
      else $error("store without its command");
   a_bad_blocks:
      assert property (bad_frame |-> !cmd_valid && !store_default)
      else $error("bad frame forwarded");
   a_vout_mode_ro:
      assert property (cmd_valid |-> cmd_code != `PMBSA_CMD_VOUT_MODE)
      else $error("format change accepted");
   a_linear_split:
      assert property (cmd_valid |-> {cmd_exponent, cmd_mantissa} == cmd_word)
      else $error("linear fields misplaced");
   a_addr_fixed:
      assert property ($past(rst_n) && $past(rst_n, 2) |-> $stable(slave_addr))
      else $error("address moved after capture");
   a_addr_range:
      assert property (slave_addr[6] == 1'h0)
      else $error("address beyond two digits");
endmodule
bind pmbsa_slave pmbsa_slave_asserts #(.STRETCH_MAX_CYC(STRETCH_MAX_CYC)) u_chk (
   .core_clk(core_clk), .rst_n(rst_n), .scl_oe(scl_oe), .alert_oe(alert_oe),
   .fault_active(fault_active), .rd_valid(rd_valid), .cmd_code(cmd_code),
   .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_mantissa(cmd_mantissa),
   .cmd_exponent(cmd_exponent), .store_default(store_default),
   .bad_frame(bad_frame), .alert_response_mode_config(alert_response_mode_config),
   .slave_addr(slave_addr)
);

// ==== test/pmbsa_master_model.sv ====
/*
 Bus master model pulling clock and data low.
 Assumes bench pull-ups resolve both wires.
*/
`timescale 1ns/1ps
module pmbsa_master_model (
   output reg scl_low,
   output reg sda_low,
   input wire scl,
   input wire sda
);
   integer hp = 32;
   integer n;
   reg smp;
   initial {scl_low, sda_low} = 2'h0;
   // 100 us limit: a stuck slave cannot hang the run
   task wait_high;
      begin
         n = 0;
         while (scl !== 1'h1 && n < 20000) begin
            #5;
            n = n + 1;
         end
      end
   endtask
   task pulse;
      begin
         #hp;
         scl_low = 1'h0;
         wait_high;
         smp = sda;
         #hp;
         scl_low = 1'h1;
      end
   endtask
   // Also serves as repeated start
   task start;
      begin
         sda_low = 1'h0;
         #hp;
         scl_low = 1'h0;
         wait_high;
         #hp;
         sda_low = 1'h1;
         #hp;
         scl_low = 1'h1;
      end
   endtask
   task stop;
      begin
         sda_low = 1'h1;
         #hp;
         scl_low = 1'h0;
         wait_high;
         #hp;
         sda_low = 1'h0;
         #hp;
      end
   endtask
   task wr_byte(input [7:0] d, output ack);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            sda_low = ~d[i];
            pulse;
         end
         sda_low = 1'h0;
         pulse;
         ack = ~smp;
      end
   endtask
   task rd_byte(output [7:0] d, input last);
      integer i;
      begin
         sda_low = 1'h0;
         for (i = 7; i >= 0; i = i - 1) begin
            pulse;
            d[i] = smp;
         end
         sda_low = ~last;
         pulse;
         sda_low = 1'h0;
      end
   endtask
endmodule

// ==== test/pmbsa_slave_tb_top.sv ====
/*
 Self-checking bench for the slave.
 Assumes the master model and hdl/ include path.
*/
`timescale 1ns/1ps
module pmbsa_slave_tb_top;
   reg core_clk = 1'h0;
   reg rst_n = 1'h0;
   reg fault_active = 1'h0;
   reg rd_valid = 1'h0;
   reg [15:0] rd_data = 16'h0000;
   reg [15:0] rd_val = 16'h0000;
   reg [7:0] pin_hi = 8'h00;
   reg [7:0] pin_lo = 8'h00;
   reg [31:0] seed = 32'h00017566;
   reg [31:0] w;
   reg [7:0] crc;
   reg [6:0] addr;
   reg [2:0] hi_d, lo_d;
   reg acks;
   reg [27:0] q[$];
   reg [27:0] e;
   integer rd_delay = 2;
   integer err_total = 0;
   integer n_tests = 0;
   wire m_scl, m_sda, scl_out, scl_oe, sda_out, sda_oe, alert_out, alert_oe;
   wire cmd_valid, store_default, bad_frame, rd_req, alert_response_mode_config;
   wire [7:0] cmd_code;
   wire [15:0] cmd_word;
   wire [6:0] slave_addr;
   wire [1:0] exp_len = (cmd_code == 8'h03 || cmd_code == 8'h11) ? 2'h0 : 2'h2;
   wire scl = ~(m_scl | (scl_oe & ~scl_out));
   wire sda = ~(m_sda | (sda_oe & ~sda_out));
   always #2.5 core_clk = ~core_clk;
   pmbsa_slave #(.STRETCH_MAX_CYC(23'h0000c8)) dut (
      .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .scl_out(scl_out),
      .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .alert_out(alert_out), .alert_oe(alert_oe), .address_high_digit_pin(pin_hi),
      .address_low_digit_pin(pin_lo), .fault_active(fault_active), .exp_len(exp_len),
      .cmd_code(cmd_code), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
      .cmd_mantissa(), .cmd_exponent(), .store_default(store_default),
      .bad_frame(bad_frame), .rd_req(rd_req), .rd_valid(rd_valid), .rd_data(rd_data),
      .alert_response_mode_config(alert_response_mode_config), .slave_addr(slave_addr)
   );
   pmbsa_master_model m (.scl_low(m_scl), .sda_low(m_sda), .scl(scl), .sda(sda));
   // ****************
   // Helpers
   // ****************
   function [31:0] rnd;
      begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
         rnd = seed;
      end
   endfunction
   function [7:0] kohm(input [2:0] d);
      kohm = d == 0 ? 8'h0a : d == 1 ? 8'h0f : d == 2 ? 8'h18 : d == 3 ? 8'h25 :
             d == 4 ? 8'h37 : d == 5 ? 8'h55 : d == 6 ? 8'h82 : 8'hc8;
   endfunction
   function [7:0] crc8(input [7:0] c, input [7:0] d);
      integer i;
      reg [7:0] x;
      begin
         x = c ^ d;
         for (i = 0; i < 8; i = i + 1)
            x = x[7] ? {x[6:0], 1'h0} ^ 8'h07 : {x[6:0], 1'h0};
         crc8 = x;
      end
   endfunction
   task chk(input string nm, input [15:0] exp, input [15:0] got);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, err_total);
         if (err_total == 0 && n_tests > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // ****************
   // Bus tasks
   // ****************
   task tx(input [7:0] b);
      reg a;
      begin
         m.wr_byte(b, a);
         acks = acks & a;
         crc = crc8(crc, b);
      end
   endtask
   task rx(output [7:0] b, input last);
      begin
         m.rd_byte(b, last);
         crc = crc8(crc, b);
      end
   endtask
   // k: 1 taken, 2 stored, 3 refused; pm: 1 good check byte, 2 bad
   task wr(input [7:0] cmd, input [15:0] v, input [1:0] nb, input [1:0] pm, input [1:0] k);
      begin
         crc = 8'h00;
         acks = 1'h1;
         m.start;
         tx({addr, 1'h0});
         tx(cmd);
         if (nb > 0) tx(v[7:0]);
         if (nb > 1) tx(v[15:8]);
         if (pm != 0) tx(crc ^ {7'h00, pm[1]});
         q.push_back({(k == 2'h1) ? nb : 2'h0, k, cmd, v});
         m.stop;
         chk("write_ack", 1'h1, acks);
         repeat (8) @(negedge core_clk);
      end
   endtask
   task rd(input [7:0] cmd, input [15:0] exp);
      reg [7:0] lo, hi, p, ep;
      begin
         crc = 8'h00;
         acks = 1'h1;
         m.start;
         tx({addr, 1'h0});
         tx(cmd);
         m.start;
         tx({addr, 1'h1});
         rx(lo, 1'h0);
         rx(hi, 1'h0);
         ep = crc;
         rx(p, 1'h1);
         m.stop;
         chk("read_word", exp, {hi, lo});
         chk("read_pec", ep, p);
         chk("read_ack", 1'h1, acks);
      end
   endtask
   task ara(input ea);
      reg [7:0] b, ep;
      begin
         crc = 8'h00;
         acks = 1'h1;
         m.start;
         tx(8'h19);
         chk("ara_ack", ea, acks);
         if (ea) begin
            rx(b, 1'h0);
            chk("ara_addr", {addr, 1'h0}, b);
            ep = crc;
            rx(b, 1'h1);
            chk("ara_pec", ep, b);
         end
         m.stop;
         repeat (8) @(negedge core_clk);
      end
   endtask
   task pulse_fault;
      begin
         @(negedge core_clk);
         fault_active = 1'h1;
         repeat (3) @(negedge core_clk);
         fault_active = 1'h0;
         repeat (2) @(negedge core_clk);
      end
   endtask
   task done(input string nm);
      $display("test %s finished", nm);
   endtask
   // ****************
   // Device side and watchers
   // ****************
   initial forever begin
      @(negedge core_clk);
      if (rd_req === 1'h1) begin
         repeat (rd_delay) @(negedge core_clk);
         if (scl_oe === 1'h1) begin
            rd_valid = 1'h1;
            rd_data = rd_val;
            @(negedge core_clk);
            rd_valid = 1'h0;
         end
      end
   end
   always @(negedge core_clk) begin
      if (rst_n && (cmd_valid || store_default || bad_frame)) begin
         e = (q.size() > 0) ? q.pop_front() : 28'h0000000;
         chk("event_kind", e[25:24], store_default ? 2'h2 : bad_frame ? 2'h3 : 2'h1);
         chk("cmd_code", e[23:16], cmd_code);
         if (e[27:26] != 2'h0) chk("cmd_word", e[15:0], cmd_word);
      end
   end
   initial begin
      #400000;
      err_total = err_total + 1;
      give_verdict;
   end
   // ****************
   // Main sequence
   // ****************
   initial begin
      w = rnd();
      hi_d = 3'h2 + w[2:0] % 3'h6;
      if (hi_d == 3'h5 || hi_d == 3'h6) hi_d = 3'h3;
      lo_d = w[5:3];
      addr = {1'h0, hi_d, lo_d};
      pin_hi = kohm(hi_d);
      pin_lo = kohm(lo_d);
      repeat (8) @(negedge core_clk);
      rst_n = 1'h1;
      repeat (6) @(negedge core_clk);
      chk("slave_addr", addr, slave_addr);
      pin_hi = 8'h0a;
      pin_lo = 8'hc8;
      repeat (4) @(negedge core_clk);
      chk("addr_hold", addr, slave_addr);
      done("address");
      w = rnd();
      wr(8'h21, w[15:0], 2'h2, 2'h0, 2'h1);
      wr(8'h21, w[31:16], 2'h2, 2'h1, 2'h1);
      wr(8'h21, w[15:0], 2'h2, 2'h2, 2'h3);
      wr(8'h21, w[15:0], 2'h1, 2'h0, 2'h3);
      wr(8'h20, 16'h0014, 2'h1, 2'h0, 2'h3);
      wr(8'h11, 16'h0000, 2'h0, 2'h1, 2'h2);
      m.hp = 1250;
      wr(8'h21, w[31:16], 2'h2, 2'h0, 2'h1);
      m.hp = 32;
      done("writes");
      rd_val = w[15:0];
      rd(8'h8b, w[15:0]);
      rd_delay = 250;
      rd(8'h8b, 16'hffff);
      rd_delay = 2;
      done("reads");
      pulse_fault;
      chk("alert_set", 1'h1, alert_oe);
      ara(1'h0);
      wr(8'h21, w[31:16], 2'h2, 2'h0, 2'h1);
      wr(8'h03, 16'h0000, 2'h0, 2'h0, 2'h1);
      chk("alert_clear", 1'h0, alert_oe);
      done("alert_default");
      wr(8'hd6, 16'h0010, 2'h1, 2'h0, 2'h1);
      chk("ara_mode", 1'h1, alert_response_mode_config);
      pulse_fault;
      acks = 1'h1;
      m.start;
      tx({addr, 1'h0});
      m.stop;
      chk("addr_refused", 1'h0, acks);
      ara(1'h1);
      chk("alert_retired", 1'h0, alert_oe);
      rd(8'h8b, w[15:0]);
      done("alert_response");
      give_verdict;
   end
endmodule
